// File: verilog/omc_consts.vh
// Constants of the optical module management controller
`ifndef OMC_CONSTS_VH
`define OMC_CONSTS_VH

// ************************************************************
// Timing
// ************************************************************
`define OMC_CLK_HZ        25000000
`define OMC_TOFF_MS       100
`define OMC_TON_MS        100
`define OMC_TOFF_CYC      ((`OMC_CLK_HZ / 1000) * `OMC_TOFF_MS)
`define OMC_TON_CYC       ((`OMC_CLK_HZ / 1000) * `OMC_TON_MS)
`define OMC_LASER_FILT    4

// ************************************************************
// Two-wire addressing
// ************************************************************
`define OMC_DEV_ADDR      7'h50

// ************************************************************
// Memory map
// ************************************************************
`define OMC_ADR_TEMP      8'h00
`define OMC_ADR_BIAS      8'h01
`define OMC_ADR_TXPWR     8'h02
`define OMC_ADR_RXPWR     8'h03
`define OMC_ADR_VCC       8'h04
`define OMC_ADR_ALARM     8'h05
`define OMC_ADR_WARN      8'h06
`define OMC_ADR_STATUS    8'h07
`define OMC_ADR_THR_BASE  8'h10
`define OMC_ADR_THR_TOP   8'h23
`define OMC_ADR_USER_BASE 8'h80

// ************************************************************
// Factory thresholds, channel n in byte n (temp is byte 0)
// ************************************************************
`define OMC_HI_ALARM      40'hf0_f0_f0_f0_f0
`define OMC_LO_ALARM      40'h10_10_10_10_10
`define OMC_HI_WARN       40'he0_e0_e0_e0_e0
`define OMC_LO_WARN       40'h20_20_20_20_20

// ************************************************************
// Reset values
// ************************************************************
`define OMC_FLAGS_RST     5'h00
`define OMC_MON_RST       8'h00

`endif

// File: verilog/omc_twi_slave.v
// Two-wire serial slave with byte pointer for the management memory
`timescale 1ns/1ps
`include "omc_consts.vh"

module omc_twi_slave
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       clr_i,
  // Synchronised bus levels
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire       active_i,
  // Data line drive
  output reg        sda_oe_o,
  // Memory side
  output reg  [7:0] addr_o,
  input  wire [7:0] rdata_i,
  output reg        rd_stb_o,
  output reg  [7:0] rd_addr_o,
  output reg        wr_stb_o,
  output reg  [7:0] wdata_o
);

  // ************************************************************
  // States
  // ************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DEV   = 3'h1;
  localparam [2:0] ST_ACK   = 3'h2;
  localparam [2:0] ST_WADR  = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [2:0] ST_RACK  = 3'h6;

  reg [2:0] state_r;
  reg [2:0] next_r;
  reg [2:0] cnt_r;
  reg [7:0] sh_r;
  reg       done_r;
  reg       nack_r;
  reg       scl_d_r;
  reg       sda_d_r;

  // Bus events seen on the synchronised levels
  wire scl_rise = scl_i & ~scl_d_r;
  wire scl_fall = ~scl_i & scl_d_r;
  wire start    = scl_i & scl_d_r & sda_d_r & ~sda_i;
  wire stop     = scl_i & scl_d_r & ~sda_d_r & sda_i;
  wire [7:0] sh_in = {sh_r[6:0], sda_i};

  // ************************************************************
  // Protocol engine
  // ************************************************************
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r   <= ST_IDLE;
      next_r    <= ST_IDLE;
      cnt_r     <= 3'h0;
      sh_r      <= 8'h00;
      done_r    <= 1'b0;
      nack_r    <= 1'b0;
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
      sda_oe_o  <= 1'b0;
      addr_o    <= 8'h00;
      rd_stb_o  <= 1'b0;
      rd_addr_o <= 8'h00;
      wr_stb_o  <= 1'b0;
      wdata_o   <= 8'h00;
    end
    else if (clr_i)
    begin
      // Bus state, pointer and strobes reset after power-down release; shift register, read address and write data kept
      state_r   <= ST_IDLE;
      next_r    <= ST_IDLE;
      cnt_r     <= 3'h0;
      done_r    <= 1'b0;
      nack_r    <= 1'b0;
      scl_d_r   <= scl_i;
      sda_d_r   <= sda_i;
      sda_oe_o  <= 1'b0;
      addr_o    <= 8'h00;
      rd_stb_o  <= 1'b0;
      wr_stb_o  <= 1'b0;
    end
    else
    begin
      scl_d_r  <= scl_i;
      sda_d_r  <= sda_i;
      rd_stb_o <= 1'b0;
      wr_stb_o <= 1'b0;
      if (!active_i)
      begin
        // Deselected: no answer, line left alone
        state_r  <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (start)
      begin
        state_r  <= ST_DEV;
        cnt_r    <= 3'h0;
        done_r   <= 1'b0;
        sda_oe_o <= 1'b0;
      end
      else if (stop)
      begin
        state_r  <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (scl_rise)
      begin
        // Incoming bits taken on the rising clock edge
        case (state_r)
          ST_DEV, ST_WADR, ST_WDATA:
          begin
            sh_r   <= sh_in;
            cnt_r  <= cnt_r + 3'h1;
            done_r <= (cnt_r == 3'h7);
          end
          ST_RACK:
            nack_r <= sda_i;
          default:
            nack_r <= nack_r;
        endcase
      end
      else if (scl_fall)
      begin
        // Outgoing changes made on the falling clock edge
        case (state_r)
          ST_DEV:
            if (done_r)
            begin
              done_r <= 1'b0;
              if (sh_r[7:1] == `OMC_DEV_ADDR)
              begin
                sda_oe_o <= 1'b1;
                state_r  <= ST_ACK;
                next_r   <= sh_r[0] ? ST_RDATA : ST_WADR;
              end
              else
                state_r <= ST_IDLE;
            end
          ST_WADR:
            if (done_r)
            begin
              // Random access: pointer loaded from the host
              done_r   <= 1'b0;
              addr_o   <= sh_r;
              sda_oe_o <= 1'b1;
              state_r  <= ST_ACK;
              next_r   <= ST_WDATA;
            end
          ST_WDATA:
            if (done_r)
            begin
              // Byte written, pointer advances
              done_r   <= 1'b0;
              wr_stb_o <= 1'b1;
              wdata_o  <= sh_r;
              addr_o   <= addr_o + 8'h01;
              sda_oe_o <= 1'b1;
              state_r  <= ST_ACK;
              next_r   <= ST_WDATA;
            end
          ST_ACK:
          begin
            cnt_r <= 3'h0;
            if (next_r == ST_RDATA)
            begin
              sh_r      <= rdata_i;
              sda_oe_o  <= ~rdata_i[7];
              rd_stb_o  <= 1'b1;
              rd_addr_o <= addr_o;
              addr_o    <= addr_o + 8'h01;
            end
            else
              sda_oe_o <= 1'b0;
            state_r <= next_r;
          end
          ST_RDATA:
          begin
            cnt_r <= cnt_r + 3'h1;
            sh_r  <= {sh_r[6:0], 1'b0};
            if (cnt_r == 3'h7)
            begin
              sda_oe_o <= 1'b0;
              state_r  <= ST_RACK;
            end
            else
              sda_oe_o <= ~sh_r[6];
          end
          ST_RACK:
            if (nack_r)
              state_r <= ST_IDLE;
            else
            begin
              // Sequential read of the next byte
              cnt_r     <= 3'h0;
              sh_r      <= rdata_i;
              sda_oe_o  <= ~rdata_i[7];
              rd_stb_o  <= 1'b1;
              rd_addr_o <= addr_o;
              addr_o    <= addr_o + 8'h01;
              state_r   <= ST_RDATA;
            end
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// File: verilog/omc_top.v
// Management side of the optical module: pins, monitors, flags, memory
`timescale 1ns/1ps
`include "omc_consts.vh"

module omc_top
#(
  parameter TOFF_CYC   = `OMC_TOFF_CYC,
  parameter TON_CYC    = `OMC_TON_CYC,
  parameter LASER_FILT = `OMC_LASER_FILT,
  parameter USER_DEPTH = 128
)
(
  // Clock and reset
  input  wire       CLK_I,
  input  wire       RESET_I,
  // Host control pins
  input  wire       SELECT_N_I,
  input  wire       LASER_OFF_REQUEST_I,
  input  wire       POWER_DOWN_I,
  // Two-wire bus (clock from host only)
  input  wire       SCL_I,
  input  wire       SDA_I,
  output reg        SDA_O,
  output reg        SDA_OE_O,
  // Host status pins
  output reg        INT_N_O,
  output reg        PRESENT_N_O,
  output reg        RX_SIGNAL_LOST_O,
  // Optical front end
  input  wire       RX_DETECT_I,
  output reg        LASER_EN_O,
  output reg        STANDBY_O,
  // Monitor values from the converter logic
  input  wire [7:0] TEMP_I,
  input  wire [7:0] BIAS_I,
  input  wire [7:0] TX_POWER_I,
  input  wire [7:0] RX_POWER_I,
  input  wire [7:0] VCC_I
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam NSYNC = 6;
  wire [NSYNC-1:0] raw_in = {RX_DETECT_I, POWER_DOWN_I, LASER_OFF_REQUEST_I,
                             SELECT_N_I, SDA_I, SCL_I};
  reg  [NSYNC-1:0] sync1_r;
  reg  [NSYNC-1:0] sync2_r;

  genvar gs;
  generate
    for (gs = 0; gs < NSYNC; gs = gs + 1)
    begin : g_sync
      // Two flops per pin, the first read by the second only
      always @(posedge CLK_I or posedge RESET_I)
      begin
        if (RESET_I)
        begin
          sync1_r[gs] <= 1'b1;
          sync2_r[gs] <= 1'b1;
        end
        else
        begin
          sync1_r[gs] <= raw_in[gs];
          sync2_r[gs] <= sync1_r[gs];
        end
      end
    end
  endgenerate

  wire scl_s   = sync2_r[0];
  wire sda_s   = sync2_r[1];
  wire sel_n_s = sync2_r[2];
  wire off_s   = sync2_r[3];
  wire pd_s    = sync2_r[4];
  wire det_s   = sync2_r[5];

  // ************************************************************
  // Power-down and module reset
  // ************************************************************
  reg pd_d_r;
  reg soft_clr_r;

  // Falling edge of power-down gives a one-cycle clear of the slave, monitors and flags
  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      pd_d_r     <= 1'b1;
      soft_clr_r <= 1'b0;
    end
    else
    begin
      pd_d_r     <= pd_s;
      soft_clr_r <= pd_d_r & ~pd_s;
    end
  end

  // ************************************************************
  // Serial slave
  // ************************************************************
  wire [7:0] mem_addr;
  reg  [7:0] mem_rdata;
  wire       rd_stb;
  wire [7:0] rd_addr;
  wire       wr_stb;
  wire [7:0] wdata;
  wire       sda_oe;

  // Works from the local clock alone, no reference clock used
  omc_twi_slave u_slave
  (
    .clk_i     (CLK_I),
    .rst_i     (RESET_I),
    .clr_i     (soft_clr_r),
    .scl_i     (scl_s),
    .sda_i     (sda_s),
    .active_i  (~sel_n_s),
    .sda_oe_o  (sda_oe),
    .addr_o    (mem_addr),
    .rdata_i   (mem_rdata),
    .rd_stb_o  (rd_stb),
    .rd_addr_o (rd_addr),
    .wr_stb_o  (wr_stb),
    .wdata_o   (wdata)
  );

  // ************************************************************
  // Live monitor values
  // ************************************************************
  reg  [39:0] mon_r;
  reg         mon_vld_r;
  wire [39:0] hi_alarm = `OMC_HI_ALARM;
  wire [39:0] lo_alarm = `OMC_LO_ALARM;
  wire [39:0] hi_warn  = `OMC_HI_WARN;
  wire [39:0] lo_warn  = `OMC_LO_WARN;

  // Sampled every cycle, frozen in standby
  // Valid only once a live sample is in: the reset value is out of range
  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      mon_r     <= {5{`OMC_MON_RST}};
      mon_vld_r <= 1'b0;
    end
    else if (soft_clr_r)
    begin
      mon_r     <= {5{`OMC_MON_RST}};
      mon_vld_r <= 1'b0;
    end
    else if (!pd_s)
    begin
      mon_r     <= {VCC_I, RX_POWER_I, TX_POWER_I, BIAS_I, TEMP_I};
      mon_vld_r <= 1'b1;
    end
  end

  // ************************************************************
  // Alarm and warning flags
  // ************************************************************
  wire [4:0] alarm_hit;
  wire [4:0] warn_hit;
  reg  [4:0] alarm_r;
  reg  [4:0] warn_r;

  genvar gc;
  generate
    for (gc = 0; gc < 5; gc = gc + 1)
    begin : g_chan
      // Out of factory range, per channel
      assign alarm_hit[gc] = (mon_r[8*gc +: 8] > hi_alarm[8*gc +: 8]) |
                             (mon_r[8*gc +: 8] < lo_alarm[8*gc +: 8]);
      assign warn_hit[gc]  = (mon_r[8*gc +: 8] > hi_warn[8*gc +: 8]) |
                             (mon_r[8*gc +: 8] < lo_warn[8*gc +: 8]);
    end
  endgenerate

  wire clr_alarm = rd_stb & (rd_addr == `OMC_ADR_ALARM);
  wire clr_warn  = rd_stb & (rd_addr == `OMC_ADR_WARN);

  // Sticky flags, cleared by reading them; a new hit wins
  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      alarm_r <= `OMC_FLAGS_RST;
      warn_r  <= `OMC_FLAGS_RST;
    end
    else if (soft_clr_r)
    begin
      alarm_r <= `OMC_FLAGS_RST;
      warn_r  <= `OMC_FLAGS_RST;
    end
    else
    begin
      alarm_r <= (clr_alarm ? 5'h00 : alarm_r) | (alarm_hit & {5{mon_vld_r}});
      warn_r  <= (clr_warn ? 5'h00 : warn_r) | (warn_hit & {5{mon_vld_r}});
    end
  end

  // ************************************************************
  // Transmitter control
  // ************************************************************
  localparam OFF_LIM = (LASER_FILT < TOFF_CYC) ? LASER_FILT : TOFF_CYC;
  localparam ON_LIM  = (LASER_FILT < TON_CYC) ? LASER_FILT : TON_CYC;
  reg  [31:0] lcnt_r;
  wire        laser_tgt = ~off_s & ~pd_s;
  wire [31:0] lim       = laser_tgt ? ON_LIM : OFF_LIM;

  // Laser follows request after a short filter, far inside 100 ms
  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      LASER_EN_O <= 1'b0;
      lcnt_r     <= 32'h0;
    end
    else if (laser_tgt == LASER_EN_O)
      lcnt_r <= 32'h0;
    else if (lcnt_r + 32'h1 >= lim)
    begin
      LASER_EN_O <= laser_tgt;
      lcnt_r     <= 32'h0;
    end
    else
      lcnt_r <= lcnt_r + 32'h1;
  end

  // ************************************************************
  // Management memory
  // ************************************************************
  reg  [7:0] user_mem [0:USER_DEPTH-1];
  wire [7:0] thr_idx  = mem_addr - `OMC_ADR_THR_BASE;
  wire [2:0] thr_ch   = thr_idx[4:2];
  wire [7:0] user_idx = mem_addr - `OMC_ADR_USER_BASE;
  wire [7:0] status   = {5'h00, STANDBY_O, RX_SIGNAL_LOST_O, LASER_EN_O};

  // Byte read mux, unmapped bytes read zero
  always @*
  begin
    mem_rdata = 8'h00;
    if (mem_addr <= `OMC_ADR_VCC)
      mem_rdata = mon_r[8*mem_addr[2:0] +: 8];
    else if (mem_addr == `OMC_ADR_ALARM)
      mem_rdata = {3'h0, alarm_r};
    else if (mem_addr == `OMC_ADR_WARN)
      mem_rdata = {3'h0, warn_r};
    else if (mem_addr == `OMC_ADR_STATUS)
      mem_rdata = status;
    else if (mem_addr >= `OMC_ADR_THR_BASE && mem_addr <= `OMC_ADR_THR_TOP)
    begin
      case (thr_idx[1:0])
        2'h0:    mem_rdata = hi_alarm[8*thr_ch +: 8];
        2'h1:    mem_rdata = lo_alarm[8*thr_ch +: 8];
        2'h2:    mem_rdata = hi_warn[8*thr_ch +: 8];
        default: mem_rdata = lo_warn[8*thr_ch +: 8];
      endcase
    end
    else if (mem_addr >= `OMC_ADR_USER_BASE)
      mem_rdata = user_mem[user_idx[6:0]];
  end

  // Writes land only in the unprotected user area
  wire [7:0] wr_addr = mem_addr - 8'h01;
  wire [7:0] wr_idx  = wr_addr - `OMC_ADR_USER_BASE;
  always @(posedge CLK_I)
  begin
    if (wr_stb && wr_addr >= `OMC_ADR_USER_BASE)
      user_mem[wr_idx[6:0]] <= wdata;
  end

  // ************************************************************
  // Output pins
  // ************************************************************
  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      SDA_O            <= 1'b0;
      SDA_OE_O         <= 1'b0;
      INT_N_O          <= 1'b1;
      PRESENT_N_O      <= 1'b0;
      RX_SIGNAL_LOST_O <= 1'b1;
      STANDBY_O        <= 1'b1;
    end
    else
    begin
      SDA_O            <= 1'b0;                            // Open drain low
      SDA_OE_O         <= sda_oe & ~sel_n_s;
      INT_N_O          <= ~(|alarm_r | |warn_r);
      PRESENT_N_O      <= 1'b0;
      RX_SIGNAL_LOST_O <= ~det_s;
      STANDBY_O        <= pd_s;
    end
  end

endmodule

// File: verif/omc_properties.sv
// Concurrent checks on the management controller pins
`timescale 1ns/1ps

module omc_checker
#(
  parameter TOFF_CYC   = 2500000,
  parameter TON_CYC    = 2500000,
  parameter LASER_FILT = 4,
  parameter USER_DEPTH = 128
)
(
  // Clock and reset
  input logic       CLK_I,
  input logic       RESET_I,
  // Host pins
  input logic       SELECT_N_I,
  input logic       LASER_OFF_REQUEST_I,
  input logic       POWER_DOWN_I,
  input logic       SCL_I,
  input logic       SDA_O,
  input logic       SDA_OE_O,
  input logic       INT_N_O,
  input logic       PRESENT_N_O,
  input logic       RX_SIGNAL_LOST_O,
  // Front end and monitors
  input logic       RX_DETECT_I,
  input logic       LASER_EN_O,
  input logic       STANDBY_O,
  input logic [7:0] TEMP_I
);
  // ********************
  // Pin relations
  // ********************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  a_present_low: assert property (!PRESENT_N_O)
    else $error("presence output not low");
  a_los_follow: assert property ($stable(RX_DETECT_I)[*5] |-> RX_SIGNAL_LOST_O == !RX_DETECT_I)
    else $error("signal lost output wrong");
  a_laser_off: assert property (LASER_OFF_REQUEST_I[*8] |=> !LASER_EN_O)
    else $error("laser still on");
  a_laser_on: assert property ((!LASER_OFF_REQUEST_I && !POWER_DOWN_I)[*8] |=> LASER_EN_O)
    else $error("laser not back on");
  a_standby_hold: assert property (POWER_DOWN_I[*8] |-> STANDBY_O && !LASER_EN_O)
    else $error("standby not held");
  a_int_alarm: assert property ((TEMP_I > 8'hf0 && !STANDBY_O)[*4] |=> !INT_N_O)
    else $error("interrupt not raised");
  a_deselect_quiet: assert property (SELECT_N_I[*4] |-> !SDA_OE_O)
    else $error("data line driven while deselected");
  a_read_edge: assert property ($rose(SDA_OE_O) |-> !SCL_I)
    else $error("data changed with clock high");
  a_hold_high: assert property (SCL_I && $past(SCL_I, 2) && !SELECT_N_I && !$past(SELECT_N_I, 4)
                                |-> $stable(SDA_OE_O))
    else $error("data moved during clock high");
  a_drive_zero: assert property (SDA_OE_O |-> !SDA_O)
    else $error("open drain drives high");

  c_read_bit: cover property ($rose(SDA_OE_O));
  c_laser_off: cover property ($fell(LASER_EN_O));
  c_standby: cover property ($rose(STANDBY_O));
  c_int_low: cover property ($fell(INT_N_O));
endmodule

bind omc_top omc_checker #(.TOFF_CYC(TOFF_CYC), .TON_CYC(TON_CYC), .LASER_FILT(LASER_FILT),
  .USER_DEPTH(USER_DEPTH)) i_chk (.CLK_I(CLK_I), .RESET_I(RESET_I), .SELECT_N_I(SELECT_N_I),
  .LASER_OFF_REQUEST_I(LASER_OFF_REQUEST_I), .POWER_DOWN_I(POWER_DOWN_I), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .INT_N_O(INT_N_O), .PRESENT_N_O(PRESENT_N_O),
  .RX_SIGNAL_LOST_O(RX_SIGNAL_LOST_O), .RX_DETECT_I(RX_DETECT_I), .LASER_EN_O(LASER_EN_O),
  .STANDBY_O(STANDBY_O), .TEMP_I(TEMP_I));

// File: verif/omc_host_model.sv
// Host board model: two-wire bus master with pulled-up data line
`timescale 1ns/1ps

module omc_host_model
(
  // Clock
  input  logic clk_i,
  // Bus lines
  output logic scl_o,
  output logic sda_o,
  // Module pull-down enable
  input  logic dut_oe_i
);
  logic host_oe;
  int   lo_extra = 0;

  // Pull-up resolves the open-drain line
  assign sda_o = ~(host_oe | dut_oe_i);

  // Clock parked high outside frames
  initial
  begin
    scl_o = 1'b1;
    host_oe = 1'b0;
  end

  // ********************
  // Bus cycles
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Data set in low phase, sampled at end of high phase
  // 320 ns bit: 5 cycles low so the module's answer settles before the rise
  task automatic bit_x(input logic b, output logic r);
    host_oe <= ~b;
    cyc(3 + lo_extra);
    scl_o <= 1'b1;
    cyc(3);
    r = sda_o;
    scl_o <= 1'b0;
    cyc(2);
  endtask

  // Data falls with clock high
  task automatic start;
    host_oe <= 1'b0;
    cyc(3);
    scl_o <= 1'b1;
    cyc(4);
    host_oe <= 1'b1;
    cyc(4);
    scl_o <= 1'b0;
    cyc(3);
  endtask

  // Data rises with clock high
  task automatic stop;
    host_oe <= 1'b1;
    cyc(3);
    scl_o <= 1'b1;
    cyc(4);
    host_oe <= 1'b0;
    cyc(4);
  endtask

  // Eight bits MSB first, then the acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, ak);
  endtask
endmodule

// File: verif/omc_testbench.sv
// Self-checking bench of the management controller
`timescale 1ns/1ps

module testbench;
  logic       clk       = 1'b0;
  logic       rst       = 1'b1;
  logic       sel_n     = 1'b0;
  logic       laser_off = 1'b0;
  logic       pdown     = 1'b0;
  logic       rx_det    = 1'b1;
  logic [7:0] temp      = 8'h30;
  logic [7:0] vcc       = 8'h70;
  logic       scl;
  logic       sda;
  logic       oe;
  logic       int_n;
  logic       pres_n;
  logic       los;
  logic       las;
  logic       stby;
  logic       ak;
  logic [7:0] junk;
  logic [7:0] buf_q [0:7];
  int         fail_count  = 0;
  int         comparisons = 0;
  int         cycles      = 0;

  omc_top #(.LASER_FILT(4)) i_dut
  (
    .CLK_I(clk), .RESET_I(rst), .SELECT_N_I(sel_n), .LASER_OFF_REQUEST_I(laser_off),
    .POWER_DOWN_I(pdown), .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(oe),
    .INT_N_O(int_n), .PRESENT_N_O(pres_n), .RX_SIGNAL_LOST_O(los), .RX_DETECT_I(rx_det),
    .LASER_EN_O(las), .STANDBY_O(stby), .TEMP_I(temp), .BIAS_I(8'h40), .TX_POWER_I(8'h50),
    .RX_POWER_I(8'h60), .VCC_I(vcc)
  );
  omc_host_model i_host (.clk_i(clk), .scl_o(scl), .sda_o(sda), .dut_oe_i(oe));

  // Clock and cycle ceiling
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // ********************
  // Access tasks
  // ********************
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write n bytes of buf_q from address a
  task automatic wr(input logic [7:0] a, input int n, input logic ea);
    i_host.start();
    i_host.xbyte(8'ha0, 1'b1, junk, ak);
    cmp("address ack", 8'(ea), 8'(ak));
    if (!ak)
    begin
      i_host.xbyte(a, 1'b1, junk, ak);
      for (int i = 0; i < n; i++) i_host.xbyte(buf_q[i], 1'b1, junk, ak);
    end
    i_host.stop();
  endtask

  // Random read of n bytes into buf_q, last one refused
  task automatic rd(input logic [7:0] a, input int n);
    i_host.start();
    i_host.xbyte(8'ha0, 1'b1, junk, ak);
    i_host.xbyte(a, 1'b1, junk, ak);
    i_host.start();
    i_host.xbyte(8'ha1, 1'b1, junk, ak);
    for (int i = 0; i < n; i++) i_host.xbyte(8'hff, i == n - 1, buf_q[i], ak);
    i_host.stop();
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ********************
  // Test sequence
  // ********************
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    cmp("present", 8'h00, 8'(pres_n));
    cmp("los", 8'h00, 8'(los));
    cmp("laser", 8'h01, 8'(las));
    rx_det <= 1'b0;
    repeat (8) @(posedge clk);
    cmp("los", 8'h01, 8'(los));
    rx_det <= 1'b1;
    laser_off <= 1'b1;
    repeat (12) @(posedge clk);
    cmp("laser", 8'h00, 8'(las));
    rd(8'h07, 1);
    cmp("status", 8'h00, buf_q[0]);
    laser_off <= 1'b0;
    repeat (12) @(posedge clk);
    rd(8'h07, 1);
    cmp("status", 8'h01, buf_q[0]);
    buf_q[0] = 8'ha5;
    buf_q[1] = 8'h5a;
    wr(8'h80, 2, 1'b0);
    rd(8'h81, 1);
    cmp("user", 8'h5a, buf_q[0]);
    rd(8'h80, 2);
    cmp("user", 8'ha5, buf_q[0]);
    cmp("user", 8'h5a, buf_q[1]);
    buf_q[0] = 8'hc3;
    buf_q[1] = 8'h33;
    wr(8'hff, 2, 1'b0);
    rd(8'hff, 2);
    cmp("wrap", 8'hc3, buf_q[0]);
    cmp("wrap", 8'h30, buf_q[1]);
    rd(8'h00, 5);
    for (int i = 0; i < 5; i++) cmp("monitor", 8'(8'h30 + 8'h10 * i), buf_q[i]);
    temp <= 8'hf5;
    vcc <= 8'h05;
    repeat (10) @(posedge clk);
    cmp("int", 8'h00, 8'(int_n));
    temp <= 8'h30;
    vcc <= 8'h70;
    rd(8'h05, 2);
    cmp("alarm", 8'h11, buf_q[0]);
    cmp("warn", 8'h11, buf_q[1]);
    repeat (6) @(posedge clk);
    cmp("int", 8'h01, 8'(int_n));
    temp <= 8'hf5;
    repeat (10) @(posedge clk);
    temp <= 8'h30;
    repeat (4) @(posedge clk);
    pdown <= 1'b1;
    repeat (10) @(posedge clk);
    cmp("standby", 8'h01, 8'(stby));
    cmp("laser", 8'h00, 8'(las));
    pdown <= 1'b0;
    repeat (12) @(posedge clk);
    cmp("int", 8'h01, 8'(int_n));
    rd(8'h80, 1);
    cmp("user", 8'ha5, buf_q[0]);
    sel_n <= 1'b1;
    buf_q[0] = 8'h99;
    repeat (4) @(posedge clk);
    wr(8'h80, 1, 1'b1);
    sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    i_host.lo_extra = 10;
    rd(8'h80, 1);
    cmp("user", 8'ha5, buf_q[0]);
    end_of_test();
  end
endmodule
